// [rmd_cfg.svh]
// Constants for the response merge and address decode block
`ifndef RMD_CFG_SVH
`define RMD_CFG_SVH
`define RMD_BUF_DEPTH 3'h4
`define RMD_M_ALLOW 3'h2
`define RMD_WREQ_LVL (`RMD_BUF_DEPTH - `RMD_M_ALLOW)
`define RMD_S_MAXBURST 5'h04
`define RMD_RD_BURST 3'h2
`define RMD_S0_SEL 3'h1
`define RMD_S1_SEL 3'h2
`define RMD_DEF_SEL 3'h4
`define RMD_S0_BASE 32'h00000000
`define RMD_S0_MASK 32'hFFFFF000
`define RMD_S0_WORD_W 10
`define RMD_S1_BASE 32'h00001000
`define RMD_S1_MASK 32'hFFFFFF00
`define RMD_S1_WORD_W 6
`define RMD_S1_SECURE 1'h1
`define RMD_SADDR_W 10
`define RMD_CNT_RST 3'h0
`define RMD_PTR_RST 2'h0
`endif

// [rmd_pkg.sv]
// Types and response ranking helpers for the response merge block
`include "rmd_cfg.svh"
package rmd_pkg;
  typedef enum logic [1:0] {
    RMD_OKAY = 2'h0,
    RMD_EXOKAY = 2'h1,
    RMD_SLVERR = 2'h2,
    RMD_DECERR = 2'h3
  } rmd_resp_t;

  typedef enum logic [2:0] {
    RMD_IDLE = 3'h0,
    RMD_RD_CMD = 3'h1,
    RMD_RD_DATA = 3'h2,
    RMD_WR_BEAT = 3'h3,
    RMD_WR_RSP = 3'h4
  } rmd_state_t;

  typedef struct packed {
    logic isRead;
    logic nonSecure;
    logic [3:0] len;
    logic [31:0] addr;
    logic [63:0] data;
  } rmd_entry_t;

  function automatic logic [1:0] rmd_rank(input rmd_resp_t r);
    case (r)
      RMD_DECERR: rmd_rank = 2'h3;
      RMD_SLVERR: rmd_rank = 2'h2;
      RMD_OKAY: rmd_rank = 2'h1;
      default: rmd_rank = 2'h0;
    endcase
  endfunction

  function automatic rmd_resp_t rmd_merge(input rmd_resp_t a, input rmd_resp_t b);
    rmd_merge = (rmd_rank(b) > rmd_rank(a)) ? b : a;
  endfunction
endpackage

// [rmd_addr_dec.sv]
// Per-master address decoder: slave select and slave word offset
`timescale 1ns/1ps
`include "rmd_cfg.svh"
module rmd_addr_dec import rmd_pkg::*; (
  input wire logic [31:0] addr,
  input wire logic nonSecure,
  output logic [2:0] sel,
  output logic [`RMD_SADDR_W-1:0] offs,
  output logic hit
);
  logic hit0;
  logic hit1;

  always_comb begin
    hit0 = (addr & `RMD_S0_MASK) == `RMD_S0_BASE;
    // Secure-only window refuses non-secure masters
    hit1 = ((addr & `RMD_S1_MASK) == `RMD_S1_BASE) && !(`RMD_S1_SECURE && nonSecure);
    hit = hit0 | hit1;
    if (hit1) begin
      sel = `RMD_S1_SEL;
      offs = {{(`RMD_SADDR_W - `RMD_S1_WORD_W){1'b0}}, addr[`RMD_S1_WORD_W+1:2]};
    end else if (hit0) begin
      sel = `RMD_S0_SEL;
      offs = addr[`RMD_S0_WORD_W+1:2];
    end else begin
      sel = `RMD_DEF_SEL;
      offs = '0;
    end
  end
endmodule // rmd_addr_dec

// [rmd_core.sv]
// Memory-mapped interconnect core: buffering, decode, burst split and response merge
`timescale 1ns/1ps
`include "rmd_cfg.svh"
module rmd_core import rmd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic mRead,
  input wire logic mWrite,
  input wire logic [31:0] mAddr,
  input wire logic [63:0] mWriteData,
  input wire logic [3:0] mBurst,
  input wire logic mNonSecure,
  input wire logic mRespEn,
  output logic mWaitReq,
  output logic mReadDataValid,
  output logic [63:0] mReadData,
  output logic [1:0] mResp,
  output logic mWriteRespValid,
  output logic [2:0] sSel,
  output logic sRead,
  output logic sWrite,
  output logic [`RMD_SADDR_W-1:0] sAddr,
  output logic [2:0] sBurst,
  output logic [31:0] sWriteData,
  input wire logic sWaitReq,
  input wire logic sReadDataValid,
  input wire logic [31:0] sReadData,
  input wire logic [1:0] sResp,
  input wire logic sWriteRespValid,
  input wire logic [2:0] slvRespEn,
  input wire logic brgRespEn
);
  typedef struct packed {
    rmd_state_t st;
    logic [2:0] bufCnt;
    logic [1:0] rdPtr;
    logic [1:0] wrPtr;
    rmd_entry_t [3:0] buff;
    logic mWaitReq;
    logic sRead;
    logic sWrite;
    logic [`RMD_SADDR_W-1:0] sAddr;
    logic [2:0] sSel;
    logic [2:0] sBurst;
    logic [31:0] sWData;
    logic [4:0] beatIdx;
    logic [4:0] total;
    logic [`RMD_SADDR_W-1:0] base;
    logic useResp;
    logic [2:0] pending;
    rmd_resp_t merged;
    logic rdBeat;
    logic [31:0] rdLo;
    logic mRdValid;
    logic [63:0] mRdData;
    rmd_resp_t mResp;
    logic mWrRespValid;
  } rmd_core_t;

  rmd_core_t q_ff;
  rmd_core_t nxt_q;
  rmd_entry_t head;
  rmd_entry_t nextEnt;
  logic [2:0] decSel;
  logic [`RMD_SADDR_W-1:0] decOffs;
  logic decHit;
  logic push;
  logic pop;
  logic acc;
  logic [4:0] nIdx;
  logic [4:0] left;
  logic [2:0] cntAfterPop;
  rmd_resp_t sRespT;

  assign head = q_ff.buff[q_ff.rdPtr];
  assign sRespT = rmd_resp_t'(sResp);

  // Single master here, so one decoder instance; a second master gets its own
  rmd_addr_dec u_dec (
    .addr(head.addr),
    .nonSecure(head.nonSecure),
    .sel(decSel),
    .offs(decOffs),
    .hit(decHit)
  );

  always_comb begin
    nxt_q = q_ff;
    nxt_q.mRdValid = 1'b0;
    nxt_q.mWrRespValid = 1'b0;
    push = mRead | mWrite;
    pop = 1'b0;
    acc = q_ff.sWrite & !sWaitReq;
    nIdx = acc ? q_ff.beatIdx + 5'h01 : q_ff.beatIdx;
    left = q_ff.total - nIdx;
    cntAfterPop = q_ff.bufCnt;
    nextEnt = head;
    case (q_ff.st)
      RMD_IDLE: begin
        if (q_ff.bufCnt != `RMD_CNT_RST) begin
          nxt_q.sSel = decSel;
          nxt_q.sAddr = decOffs;
          nxt_q.base = decOffs;
          nxt_q.merged = RMD_EXOKAY;
          nxt_q.pending = `RMD_CNT_RST;
          // Endpoint answers only when it carries responses and, unless it is the default slave, the bridge does too
          nxt_q.useResp = ((slvRespEn & decSel) != 3'h0) && (brgRespEn || decSel == `RMD_DEF_SEL);
          if (head.isRead) begin
            pop = 1'b1;
            nxt_q.sRead = 1'b1;
            nxt_q.sBurst = `RMD_RD_BURST;
            nxt_q.rdBeat = 1'b0;
            nxt_q.st = RMD_RD_CMD;
          end else begin
            nxt_q.total = {head.len, 1'b0};
            nxt_q.beatIdx = 5'h00;
            nxt_q.sWrite = 1'b1;
            nxt_q.sWData = head.data[31:0];
            nxt_q.sBurst = ({head.len, 1'b0} > `RMD_S_MAXBURST) ? 3'h4 : {head.len[1:0], 1'b0};
            nxt_q.st = RMD_WR_BEAT;
          end
        end
      end
      RMD_RD_CMD: begin
        if (!sWaitReq) begin
          nxt_q.sRead = 1'b0;
          nxt_q.st = RMD_RD_DATA;
        end
      end
      RMD_RD_DATA: begin
        if (sReadDataValid) begin
          nxt_q.merged = rmd_merge(q_ff.merged, sRespT);
          nxt_q.rdBeat = 1'b1;
          if (!q_ff.rdBeat) begin
            nxt_q.rdLo = sReadData;
          end else begin
            nxt_q.mRdValid = 1'b1;
            nxt_q.mRdData = {sReadData, q_ff.rdLo};
            // Response field is don't-care for a master without responses
            nxt_q.mResp = (q_ff.useResp && mRespEn) ? rmd_merge(q_ff.merged, sRespT) : RMD_OKAY;
            nxt_q.st = RMD_IDLE;
          end
        end
      end
      RMD_WR_BEAT: begin
        if (acc && q_ff.beatIdx[0]) begin
          pop = 1'b1;
        end
        if (acc && q_ff.beatIdx[1:0] == 2'h0 && q_ff.useResp) begin
          nxt_q.pending = q_ff.pending + 3'h1;
        end
        if (!(q_ff.sWrite && !acc)) begin
          cntAfterPop = q_ff.bufCnt - {2'h0, pop};
          nextEnt = pop ? q_ff.buff[q_ff.rdPtr + 2'h1] : head;
          nxt_q.beatIdx = nIdx;
          nxt_q.sWrite = 1'b0;
          if (nIdx == q_ff.total) begin
            if (q_ff.useResp) begin
              nxt_q.st = RMD_WR_RSP;
            end else begin
              nxt_q.mWrRespValid = mRespEn;
              nxt_q.mResp = RMD_OKAY;
              nxt_q.st = RMD_IDLE;
            end
          end else if (cntAfterPop != `RMD_CNT_RST) begin
            // Stall between beats when the master has not yet supplied data
            nxt_q.sWrite = 1'b1;
            nxt_q.sWData = nIdx[0] ? nextEnt.data[63:32] : nextEnt.data[31:0];
            if (nIdx[1:0] == 2'h0) begin
              nxt_q.sAddr = q_ff.base + {{(`RMD_SADDR_W - 5){1'b0}}, nIdx};
              nxt_q.sBurst = (left > `RMD_S_MAXBURST) ? 3'h4 : left[2:0];
            end
          end
        end
      end
      RMD_WR_RSP: begin
        if (nxt_q.pending == `RMD_CNT_RST) begin
          nxt_q.mWrRespValid = mRespEn;
          nxt_q.mResp = mRespEn ? q_ff.merged : RMD_OKAY;
          nxt_q.st = RMD_IDLE;
        end
      end
      default: begin
        nxt_q.st = RMD_IDLE;
      end
    endcase
    // Write responses are drained even for a non-responding master so none go stale
    if (sWriteRespValid && q_ff.useResp && q_ff.pending != `RMD_CNT_RST) begin
      nxt_q.pending = nxt_q.pending - 3'h1;
      nxt_q.merged = rmd_merge(q_ff.merged, sRespT);
      if (q_ff.st == RMD_WR_RSP && nxt_q.pending == `RMD_CNT_RST) begin
        nxt_q.mWrRespValid = mRespEn;
        nxt_q.mResp = mRespEn ? rmd_merge(q_ff.merged, sRespT) : RMD_OKAY;
        nxt_q.st = RMD_IDLE;
      end
    end
    if (push) begin
      nxt_q.buff[q_ff.wrPtr] = '{isRead: mRead, nonSecure: mNonSecure, len: mBurst, addr: mAddr, data: mWriteData};
      nxt_q.wrPtr = q_ff.wrPtr + 2'h1;
    end
    if (pop) begin
      nxt_q.rdPtr = q_ff.rdPtr + 2'h1;
    end
    nxt_q.bufCnt = q_ff.bufCnt + {2'h0, push} - {2'h0, pop};
    // Wait early enough that the master's allowance still fits in the buffer
    nxt_q.mWaitReq = nxt_q.bufCnt >= `RMD_WREQ_LVL;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign mWaitReq = q_ff.mWaitReq;
  assign mReadDataValid = q_ff.mRdValid;
  assign mReadData = q_ff.mRdData;
  assign mResp = q_ff.mResp;
  assign mWriteRespValid = q_ff.mWrRespValid;
  assign sSel = q_ff.sSel;
  assign sRead = q_ff.sRead;
  assign sWrite = q_ff.sWrite;
  assign sAddr = q_ff.sAddr;
  assign sBurst = q_ff.sBurst;
  assign sWriteData = q_ff.sWData;

  a_buf_no_loss: assert property (@(posedge clk) disable iff (reset)
    (mRead | mWrite) && !$past(q_ff.mWaitReq, 3) |-> q_ff.bufCnt < `RMD_BUF_DEPTH)
    else $error("transfer arrived with buffer full");
  a_sel_onehot: assert property (@(posedge clk) disable iff (reset)
    (sRead || sWrite) |-> $onehot(sSel))
    else $error("slave select not one-hot");
  a_default_route: assert property (@(posedge clk) disable iff (reset)
    q_ff.st == RMD_IDLE && q_ff.bufCnt != 3'h0 && !decHit |=> sSel == `RMD_DEF_SEL)
    else $error("unmapped access not sent to default slave");
  a_addr_trim: assert property (@(posedge clk) disable iff (reset)
    (sRead || sWrite) && sSel == `RMD_S1_SEL |-> sAddr[`RMD_SADDR_W-1:`RMD_S1_WORD_W] == '0)
    else $error("upper address bits leak to small slave");
  a_okay_gen: assert property (@(posedge clk) disable iff (reset)
    mWriteRespValid && !q_ff.useResp |-> mResp == RMD_OKAY)
    else $error("generated response not OKAY");
  a_no_resp_mst: assert property (@(posedge clk) disable iff (reset)
    !$past(mRespEn) |-> !mWriteRespValid)
    else $error("write response to master without responses");
  a_merge_rank: assert property (@(posedge clk) disable iff (reset)
    q_ff.st == RMD_RD_DATA && sReadDataValid && q_ff.useResp && mRespEn && q_ff.rdBeat
    |=> mReadDataValid && rmd_rank(rmd_resp_t'(mResp)) >= rmd_rank($past(sRespT)))
    else $error("merged response ranks below a part");
  a_single_resp: assert property (@(posedge clk) disable iff (reset)
    mWriteRespValid |-> $past(q_ff.pending) <= 3'h1 && q_ff.pending == 3'h0 ##1 !mWriteRespValid)
    else $error("write response before all parts collected");
  a_burst_max: assert property (@(posedge clk) disable iff (reset)
    sWrite |-> sBurst != 3'h0 && sBurst <= 3'h4)
    else $error("slave write burst out of range");
endmodule // rmd_core

// [rmd_slave_model.sv]
// Slave-side partner model: stalls, read beats and write responses
`timescale 1ns/1ps
`include "rmd_cfg.svh"
module rmd_slave_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic stallEn,
  input wire logic [1:0] rspA,
  input wire logic [1:0] rspB,
  input wire logic [2:0] sSel,
  input wire logic sRead,
  input wire logic sWrite,
  input wire logic [`RMD_SADDR_W-1:0] sAddr,
  input wire logic [2:0] sBurst,
  output logic sWaitReq,
  output logic sReadDataValid,
  output logic [31:0] sReadData,
  output logic [1:0] sResp,
  output logic sWriteRespValid
);
  logic tgl, alt, def;
  logic [2:0] rdLeft, wrLeft;
  logic [7:0] beat;
  logic [`RMD_SADDR_W-1:0] rdAddr;
  logic [31:0] dat;
  logic [1:0] rsp;
  assign sWaitReq = stallEn & tgl;
  // Idle lines invert so a stale value never looks valid
  assign sReadData = sReadDataValid ? dat : ~dat;
  assign sResp = (sReadDataValid | sWriteRespValid) ? rsp : ~rsp;
  always_ff @(posedge clk) begin
    sReadDataValid <= 1'b0;
    sWriteRespValid <= 1'b0;
    tgl <= ~tgl;
    if (reset) begin
      tgl <= 1'b0;
      alt <= 1'b0;
      rdLeft <= 3'h0;
      wrLeft <= 3'h0;
      dat <= 32'h0;
      rsp <= 2'h0;
      def <= 1'b0;
    end else if (rdLeft != 3'h0 && !sWaitReq) begin
      sReadDataValid <= 1'b1;
      dat <= {8'hA5, beat, 6'h00, rdAddr};
      // Default slave always answers with a decode error
      rsp <= def ? 2'h3 : (alt ? rspB : rspA);
      alt <= ~alt;
      beat <= beat + 8'h01;
      rdLeft <= rdLeft - 3'h1;
    end else if (sRead && !sWaitReq) begin
      rdLeft <= sBurst;
      rdAddr <= sAddr;
      def <= sSel[2];
      beat <= 8'h00;
    end else if (sWrite && !sWaitReq) begin
      wrLeft <= (wrLeft == 3'h0) ? sBurst - 3'h1 : wrLeft - 3'h1;
      if (wrLeft == 3'h1 || (wrLeft == 3'h0 && sBurst == 3'h1)) begin
        sWriteRespValid <= 1'b1;
        rsp <= sSel[2] ? 2'h3 : (alt ? rspB : rspA);
        alt <= ~alt;
      end
    end
  end
endmodule // rmd_slave_model

// [response_merge_decode_tb.sv]
// Self-checking bench for the response merge and address decode core
`timescale 1ns/1ps
`include "rmd_cfg.svh"
module response_merge_decode_tb;
  logic clk = 1'b0, reset = 1'b1, mRead = 1'b0, mWrite = 1'b0, mNonSecure = 1'b0;
  logic mRespEn = 1'b1, brgRespEn = 1'b1, stallEn = 1'b0, waitSeen = 1'b0;
  logic [31:0] mAddr = 32'h0;
  logic [63:0] mWriteData = 64'h0;
  logic [3:0] mBurst = 4'h1;
  logic [2:0] slvRespEn = 3'h7;
  logic [1:0] rspA = 2'h0, rspB = 2'h0;
  logic mWaitReq, mReadDataValid, mWriteRespValid, sRead, sWrite, sWaitReq, sReadDataValid, sWriteRespValid;
  logic [63:0] mReadData, rdSeen;
  logic [1:0] mResp, sResp, rspSeen;
  logic [2:0] sSel, sBurst, selSeen;
  logic [`RMD_SADDR_W-1:0] sAddr, addrSeen;
  logic [31:0] sWriteData, sReadData;
  int errCount = 0, totalChecks = 0, nRd = 0, nWr = 0, nSub = 0, wrBeat = 0, wdBad = 0;

  always #2 clk = ~clk;

  rmd_core dut (.clk(clk), .reset(reset), .mRead(mRead), .mWrite(mWrite), .mAddr(mAddr),
    .mWriteData(mWriteData), .mBurst(mBurst), .mNonSecure(mNonSecure), .mRespEn(mRespEn),
    .mWaitReq(mWaitReq), .mReadDataValid(mReadDataValid), .mReadData(mReadData), .mResp(mResp),
    .mWriteRespValid(mWriteRespValid), .sSel(sSel), .sRead(sRead), .sWrite(sWrite), .sAddr(sAddr),
    .sBurst(sBurst), .sWriteData(sWriteData), .sWaitReq(sWaitReq), .sReadDataValid(sReadDataValid),
    .sReadData(sReadData), .sResp(sResp), .sWriteRespValid(sWriteRespValid), .slvRespEn(slvRespEn),
    .brgRespEn(brgRespEn));
  rmd_slave_model slv (.clk(clk), .reset(reset), .stallEn(stallEn), .rspA(rspA), .rspB(rspB),
    .sSel(sSel), .sRead(sRead), .sWrite(sWrite), .sAddr(sAddr), .sBurst(sBurst), .sWaitReq(sWaitReq),
    .sReadDataValid(sReadDataValid), .sReadData(sReadData), .sResp(sResp),
    .sWriteRespValid(sWriteRespValid));

  always @(posedge clk) begin
    if (mReadDataValid === 1'b1) begin
      nRd++;
      rdSeen = mReadData;
      rspSeen = mResp;
    end
    if (mWriteRespValid === 1'b1) begin
      nWr++;
      rspSeen = mResp;
    end
    if (sWriteRespValid === 1'b1) nSub++;
    // Accepted slave beats: low half of each master beat first
    if (sWrite === 1'b1 && sWaitReq === 1'b0) begin
      if (sWriteData !== (wrBeat[0] ? 32'(wrBeat / 2) + 32'h10 : 32'(wrBeat / 2))) wdBad++;
      wrBeat++;
    end
    if (sRead === 1'b1) begin
      selSeen = sSel;
      addrSeen = sAddr;
    end
    if (mWaitReq === 1'b1) waitSeen = 1'b1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] expv);
    totalChecks++;
    if (seen !== expv) begin
      errCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task automatic finalReport();
    if (errCount == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Settle window after the target also catches a duplicated answer
  task automatic waitFor(ref int cnt, input int target);
    for (int i = 0; i < 300 && cnt < target; i++) @(negedge clk);
    repeat (8) @(negedge clk);
    check(64'(cnt), 64'(target));
    if (cnt < target) finalReport();
  endtask

  function automatic logic [63:0] expData(input logic [9:0] a);
    expData = {8'hA5, 8'h01, 6'h00, a, 8'hA5, 8'h00, 6'h00, a};
  endfunction

  // Swap the two low codes so a plain compare follows the ranking
  function automatic logic [1:0] mergeExp(input logic [1:0] a, input logic [1:0] b);
    mergeExp = ((b ^ {1'b0, ~b[1]}) > (a ^ {1'b0, ~a[1]})) ? b : a;
  endfunction

  task automatic doRead(input logic [31:0] a, input logic ns, input logic [1:0] ra, input logic [1:0] rb);
    int n;
    n = nRd;
    @(negedge clk);
    rspA = ra;
    rspB = rb;
    mAddr = a;
    mNonSecure = ns;
    mRead = 1'b1;
    @(negedge clk);
    mRead = 1'b0;
    waitFor(nRd, n + 1);
  endtask

  task automatic doWrite(input logic [3:0] len, input logic [1:0] ra, input logic [1:0] rb, input logic [1:0] er);
    int s, w, i;
    s = nSub;
    w = nWr;
    rspA = ra;
    rspB = rb;
    i = 0;
    wrBeat = 0;
    wdBad = 0;
    for (int j = 0; j < 100 && i < len; j++) begin
      @(negedge clk);
      // Pushes only while not stalled, so the allowance is never exceeded
      mWrite = (mWaitReq === 1'b0);
      mAddr = 32'h100;
      mBurst = len;
      mWriteData = {32'(i) + 32'h10, 32'(i)};
      if (mWaitReq === 1'b0) i++;
    end
    check(64'(i), 64'(len));
    if (i < len) finalReport();
    @(negedge clk);
    mWrite = 1'b0;
    if (mRespEn) begin
      waitFor(nWr, w + 1);
      check(64'(nSub - s), 64'((2 * len + 3) / 4));
      check(64'(rspSeen), 64'(er));
    end else begin
      waitFor(nSub, s + (2 * len + 3) / 4);
      check(64'(nWr), 64'(w));
    end
    check(64'(wrBeat), 64'(2 * len));
    check(64'(wdBad), 64'h0);
  endtask

  task automatic decodeCase(input logic [31:0] a, input logic ns, input logic [1:0] mr, input logic [12:0] so,
                            input logic [1:0] r);
    doRead(a, ns, mr, mr);
    check(64'({selSeen, addrSeen}), 64'(so));
    check(64'(rspSeen), 64'(r));
  endtask

  task automatic scnReadMerge();
    logic [1:0] pa [4] = '{2'h1, 2'h0, 2'h2, 2'h1};
    logic [1:0] pb [4] = '{2'h1, 2'h1, 2'h0, 2'h3};
    for (int k = 0; k < 4; k++) begin
      doRead(32'h0ABC, 1'b0, pa[k], pb[k]);
      check(rdSeen, expData(10'h2AF));
      check(64'(rspSeen), 64'(mergeExp(pa[k], pb[k])));
      check(64'({selSeen, addrSeen}), 64'({3'h1, 10'h2AF}));
    end
  endtask

  task automatic scnBuffer();
    int n;
    n = nRd;
    waitSeen = 1'b0;
    stallEn = 1'b1;
    rspA = 2'h0;
    rspB = 2'h0;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      mRead = 1'b1;
      mAddr = 32'(k * 4);
    end
    @(negedge clk);
    mRead = 1'b0;
    waitFor(nRd, n + 4);
    check(64'(waitSeen), 64'h1);
    check(rdSeen, expData(10'h003));
    stallEn = 1'b0;
  endtask

  task automatic scnWriteMerge();
    doWrite(4'h3, 2'h2, 2'h0, 2'h2);
    stallEn = 1'b1;
    doWrite(4'h8, 2'h1, 2'h1, 2'h1);
    stallEn = 1'b0;
  endtask

  task automatic scnNoResp();
    slvRespEn = 3'h6;
    doWrite(4'h1, 2'h3, 2'h3, 2'h0);
    decodeCase(32'h0ABC, 1'b0, 2'h3, {3'h1, 10'h2AF}, 2'h0);
    slvRespEn = 3'h7;
    brgRespEn = 1'b0;
    doWrite(4'h2, 2'h3, 2'h3, 2'h0);
    brgRespEn = 1'b1;
    mRespEn = 1'b0;
    doWrite(4'h2, 2'h3, 2'h3, 2'h0);
    slvRespEn = 3'h6;
    doWrite(4'h1, 2'h3, 2'h3, 2'h0);
  endtask

  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    scnReadMerge();
    decodeCase(32'h1010, 1'b0, 2'h0, {3'h2, 10'h004}, 2'h0);
    decodeCase(32'h1010, 1'b1, 2'h0, {3'h4, 10'h000}, 2'h3);
    decodeCase(32'h2000, 1'b0, 2'h0, {3'h4, 10'h000}, 2'h3);
    scnBuffer();
    scnWriteMerge();
    scnNoResp();
    finalReport();
  end
endmodule // response_merge_decode_tb
